// ==== core/tsc_pkg.sv ====
// shared constants and types for the trim dac tracking servo controller
package tsc_pkg;
	localparam int NCH = 2;
	localparam int AW = 8;
	localparam int CW = 24;
	localparam int DW = 10;
	// register byte addresses
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_STAT = 8'h04;
	localparam logic [AW-1:0] A_CH_BASE = 8'h10;
	localparam logic [AW-1:0] A_CH1 = 8'h20;
	localparam logic [AW-1:0] A_CH_END = 8'h30;
	localparam int OFF_W = 4;
	localparam logic [OFF_W-1:0] O_IDAC = 4'h0;
	localparam logic [OFF_W-1:0] O_TRACK = 4'h4;
	localparam logic [OFF_W-1:0] O_DELAY = 4'h8;
	localparam logic [OFF_W-1:0] O_SERVO = 4'hC;
	// control register fields
	localparam int C_GO = 0;
	localparam int C_SYNC = 1;
	localparam int C_RUN = 2;
	localparam int C_PEND = 4;
	localparam int C_CFGLO = 5;
	localparam int C_BUSY = 6;
	// track and servo register fields
	localparam int T_EN = 8;
	localparam int T_POL = 9;
	localparam int S_EN = 15;
	localparam int SW = 15;
	// status: one field group per channel
	localparam int ST_W = 6;
	// dac codes
	localparam logic [7:0] DAC_MIN = 8'h00;
	localparam logic [7:0] DAC_MID = 8'h80;
	localparam logic [7:0] DAC_MAX = 8'hFF;
	localparam logic [1:0] CONF_N = 2'h2;
	// timing, in ns, and derived cycle counts
	localparam int CLK_NS = 100;
	localparam int STEP_NS = 1000;
	localparam int HOLD_NS = 100000;
	localparam int SETTLE_NS = 10000;
	localparam int SYNC_NS = 1000000;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC = SYNC_NS / CLK_NS;

	typedef enum logic [1:0] {
		TR_IDLE = 2'b00,
		TR_SETTLE = 2'b01,
		TR_RUN = 2'b10,
		TR_HOLD = 2'b11
	} tsc_trk_e;

	typedef enum logic [1:0] {
		SY_IDLE = 2'b00,
		SY_DRAIN = 2'b01,
		SY_WAIT = 2'b10
	} tsc_sync_e;

	typedef struct packed {
		logic refault;
		logic rep;
		logic en;
		logic con;
		logic pol;
		logic [7:0] code;
	} tsc_idac_s;

	typedef struct packed {
		logic valid;
		logic is_a;
		logic ch;
		logic [SW-1:0] res;
		logic uv;
		logic ov;
	} tsc_conv_s;

	typedef struct packed {
		logic cfg;
		logic [NCH-1:0] run;
		logic [NCH-1:0] comp;
	} tsc_pins_s;
endpackage

// ==== core/tsc_ctrl.sv ====
// tracking and voltage servo sequencer for two trim dacs, apb slave
//
// How it works
// (R1) tracking pending while config pin high and any run pin high
// (R2) sync write: finish conversion, wait for go, give up on timeout
// (R3) host reads sync flag back before issuing go to the group
// (R4) host hard connects, sets track regs, releases run pins, then go
// (R5) go: delay counts down per step, then code steps once per step
// (R6) power-up: track enable clears at target; config low; hold; dacs off
// (R7) power-up refused for a channel not connected
// (R8) track pol, track enable and code writes ignored while locked
// (R9) power-down: soft connect, release config pin, settle, then count
// (R10) power-down: ramp to target, then clear both track enables
// (R11) power-down go ignored while any tracked dac still enabled
// (R12) host may pull run pins low after power-down ends
// (R13) servo steps code up, down or holds after each servo conversion
// (R14) servo write clears reached; fast mode; two slow conversions
// (R15) other channels' conversions held until servo reached
// (R16) servo enable forced low while dac disabled
// (R17) host connects the dac before asking for servo
// (R18) dac limit fault during continuous servo keeps servoing
// (R19) servo enable cleared while tracking pending or running
// (R20) one-time servo stops updating once reached
// (R21) re-servo on fault: uv or ov clears reached, servo again
// (R22) persistent fault: other channels served after each attempt
// (R23) ten bit start delay per channel
// (R24) soft connect ramps from mid until comparator trips or limit
// (R25) dac limit fault evaluated after each round of conversions
// (R26) step, hold, settle and sync times are cycle count parameters
// (R27) two channels run independently, sharing go, pin and adc
//
// Register access over APB and the register offsets were left to the implementer.
module tsc_ctrl
	import tsc_pkg::*;
#(
	parameter int STEP_C = tsc_pkg::STEP_CYC,
	parameter int HOLD_C = tsc_pkg::HOLD_CYC,
	parameter int SETTLE_C = tsc_pkg::SETTLE_CYC,
	parameter int SYNC_C = tsc_pkg::SYNC_CYC
) (
	input  wire logic                   clk,        // 10 mhz
	input  wire logic                   nrst,       // async reset
	input  wire logic                   psel,       // apb select
	input  wire logic                   penable,    // apb access
	input  wire logic                   pwrite,     // apb direction
	input  wire logic [tsc_pkg::AW-1:0] paddr,      // apb address
	input  wire logic [31:0]            pwdata,     // apb write data
	output logic      [31:0]            prdata,     // apb read data
	output logic                        pready,     // apb ready
	output logic                        pslverr,    // unmapped
	input  tsc_pkg::tsc_pins_s          pins_i,     // async pin levels
	output logic                        cfg_o,      // config pin out
	output logic                        cfg_oe,     // config pull low
	output logic      [tsc_pkg::NCH-1:0] run_o,     // run pins out
	output logic      [tsc_pkg::NCH-1:0] run_oe,    // run pull low
	output logic [tsc_pkg::NCH-1:0][7:0] dac_code, // dac codes
	output logic      [tsc_pkg::NCH-1:0] dac_on,    // buffer linked
	input  wire logic                   adc_busy,   // conversion on
	input  tsc_pkg::tsc_conv_s          conv_i,     // conversion end
	input  wire logic                   round_done, // all convs done
	output logic                        adc_fast,   // 12-bit mode
	output logic                        adc_hold_oth, // hold others
	output logic                        adc_hold_all  // hold all
);
	import tsc_pkg::*;

	localparam int PW = $bits(tsc_pins_s);
	localparam int IW = $bits(tsc_idac_s);

	// timing counts must fit the shared counter
	if (STEP_C < 1 || HOLD_C < 1 || SETTLE_C < 1 || SYNC_C < 1 ||
			SYNC_C >= 2 ** CW || HOLD_C >= 2 ** CW) begin : g_bad
		$error("timing count out of range");
	end

	// channel window decode: {hit, channel}
	function automatic logic [1:0] chdec(input logic [AW-1:0] a);
		logic hit;
		hit = (a >= A_CH_BASE) && (a < A_CH_END) && (a[1:0] == 2'b00);
		return {hit, a >= A_CH1};
	endfunction

	logic [PW-1:0] s1_q, s2_q, s3_q, pin_q;
	tsc_pins_s pf;
	tsc_idac_s idac_q [NCH];
	logic [7:0] ttgt_q [NCH];
	logic [DW-1:0] dly_q [NCH];
	logic [DW-1:0] dcnt_q [NCH];
	logic [SW-1:0] svt_q [NCH];
	logic [1:0] cf_q [NCH];
	logic [NCH-1:0] ten_q, tpol_q, sv_en_q, done_q, rch_q;
	logic [NCH-1:0] dir_q, lastv_q, flt_q, sc_q, scf_q, scr_q, act_q;
	logic [NCH-1:0] sv_act, lo, eq, inc, cv, refire, en_v;
	logic [NCH-1:0] run_rel_q;
	logic [1:0] wdec;
	logic [OFF_W-1:0] off;
	logic wr, go_w, sync_w, pend, lock, tick;
	logic start_up, start_dn, run_end, hold_end, retry_q, cfg_low_q, dn_q;
	logic [CW-1:0] stp_q, tmr_q, syt_q;
	tsc_trk_e trk_st;
	tsc_sync_e sy_st;
	tsc_idac_s wi;
	logic [31:0] rd_d;

	// three stage pin sampler; a bit moves once stages two and three agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
		end
	end
	assign pf = pin_q;

	// bus decode; slave never stalls
	assign pready = 1'b1;
	assign wdec = chdec(paddr);
	assign off = paddr[OFF_W-1:0];
	assign wr = psel && penable && pwrite;
	assign pslverr = psel && penable && !wdec[1] &&
		(paddr != A_CTRL) && (paddr != A_STAT);
	assign go_w = wr && (paddr == A_CTRL) && pwdata[C_GO] &&
		(sy_st != SY_DRAIN);
	assign sync_w = wr && (paddr == A_CTRL) && pwdata[C_SYNC];
	assign wi = tsc_idac_s'(pwdata[IW-1:0]);

	// tracking range and lockout
	assign pend = pf.cfg && (|pf.run); // R1
	assign lock = pend || (trk_st != TR_IDLE); // R8
	assign start_up = go_w && (trk_st == TR_IDLE) && pend; // R5
	assign start_dn = go_w && (trk_st == TR_IDLE) && !pend &&
		(|ten_q) && !(|(ten_q & en_v)); // R11
	assign run_end = (trk_st == TR_RUN) && !(|act_q);
	assign hold_end = (trk_st == TR_HOLD) && (tmr_q == '0);

	// per channel servo terms
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			en_v[c] = idac_q[c].en;
			sv_act[c] = sv_en_q[c] && idac_q[c].en && idac_q[c].con &&
				(!done_q[c] || idac_q[c].rep); // R20
			lo[c] = $signed(conv_i.res) < $signed(svt_q[c]);
			eq[c] = conv_i.res == svt_q[c];
			inc[c] = lo[c] ~^ idac_q[c].pol;
			cv[c] = conv_i.valid && conv_i.is_a && (conv_i.ch == 1'(c));
			refire[c] = cv[c] && done_q[c] && idac_q[c].refault &&
				!idac_q[c].rep && (conv_i.uv || conv_i.ov); // R21
		end
	end

	// adc scheduling requests
	assign adc_fast = |(sv_act & ~rch_q & ~done_q); // R14
	assign adc_hold_oth = (|(sv_act & ~done_q)) && !retry_q; // R15 R22
	assign adc_hold_all = lock || (sy_st != SY_IDLE);

	// pins and dac outputs
	assign cfg_o = 1'b0;
	assign cfg_oe = cfg_low_q;
	assign run_o = '0;
	assign run_oe = ~run_rel_q;
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			dac_code[c] = idac_q[c].code;
			dac_on[c] = idac_q[c].en && idac_q[c].con;
		end
	end

	// step period tick, free running
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stp_q <= '0;
		end else if (stp_q == '0) begin
			stp_q <= CW'(STEP_C - 1); // R26
		end else begin
			stp_q <= stp_q - 1'b1;
		end
	end
	assign tick = (stp_q == '0);

	// run pin release bits; reset holds supplies off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_rel_q <= '0;
		end else if (wr && paddr == A_CTRL) begin
			run_rel_q <= pwdata[C_RUN +: NCH]; // R12
		end
	end

	// group sync: drain the conversion, then wait for go or timeout
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sy_st <= SY_IDLE;
			syt_q <= '0;
		end else begin
			case (sy_st)
				SY_IDLE: begin
					if (sync_w) begin
						sy_st <= SY_DRAIN; // R2
					end
				end
				SY_DRAIN: begin
					if (!adc_busy) begin
						sy_st <= SY_WAIT;
						syt_q <= CW'(SYNC_C);
					end
				end
				SY_WAIT: begin
					if (go_w || syt_q == '0) begin
						sy_st <= SY_IDLE; // R2
					end else begin
						syt_q <= syt_q - 1'b1;
					end
				end
				default: sy_st <= SY_IDLE;
			endcase
		end
	end

	// global tracking sequence, shared by both channels
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			trk_st <= TR_IDLE;
			tmr_q <= '0;
			cfg_low_q <= 1'b0;
			dn_q <= 1'b0;
		end else begin
			case (trk_st)
				// pending rises again while powering down, so keep the way
				TR_IDLE: begin
					if (start_up) begin
						trk_st <= TR_RUN;
						dn_q <= 1'b0;
					end else if (start_dn) begin
						trk_st <= TR_SETTLE;
						dn_q <= 1'b1;
						cfg_low_q <= 1'b0; // R9
						tmr_q <= CW'(SETTLE_C);
					end
				end
				TR_SETTLE: begin
					if (tmr_q == '0) begin
						trk_st <= TR_RUN; // R9
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				TR_RUN: begin
					if (run_end && !dn_q) begin
						trk_st <= TR_HOLD;
						cfg_low_q <= 1'b1; // R6
						tmr_q <= CW'(HOLD_C);
					end else if (run_end) begin
						trk_st <= TR_IDLE;
					end
				end
				TR_HOLD: begin
					if (tmr_q == '0) begin
						trk_st <= TR_IDLE;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: trk_st <= TR_IDLE;
			endcase
		end
	end

	// a fault retry lets one full round of other channels through
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			retry_q <= 1'b0;
		end else if (|refire) begin
			retry_q <= 1'b1; // R22
		end else if (round_done) begin
			retry_q <= 1'b0;
		end
	end

	// channel state; later assignments win, so hardware sets follow
	// the software clears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int c = 0; c < NCH; c++) begin
				idac_q[c] <= '0;
				ttgt_q[c] <= '0;
				dly_q[c] <= '0;
				dcnt_q[c] <= '0;
				svt_q[c] <= '0;
				cf_q[c] <= '0;
			end
			{ten_q, tpol_q, sv_en_q, done_q, rch_q} <= '0;
			{dir_q, lastv_q, flt_q, sc_q, scf_q, scr_q, act_q} <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin // R27
				// software writes
				if (wr && wdec[1] && wdec[0] == 1'(c)) begin
					case (off)
						O_IDAC: begin
							idac_q[c].rep <= wi.rep;
							idac_q[c].refault <= wi.refault;
							if (lock || sc_q[c]) begin
								// R8
							end else if (!wi.en) begin
								idac_q[c].en <= 1'b0;
								idac_q[c].con <= 1'b0;
								scf_q[c] <= 1'b0;
							end else if (scf_q[c]) begin
								// failed soft connect must be disabled first
							end else if (!idac_q[c].en && !wi.con) begin
								idac_q[c].en <= 1'b1; // R24
								idac_q[c].pol <= wi.pol;
								idac_q[c].code <= DAC_MID;
								sc_q[c] <= 1'b1;
								scr_q[c] <= pf.comp[c];
							end else if (!idac_q[c].en || (idac_q[c].con
									&& !sv_en_q[c])) begin
								idac_q[c].en <= 1'b1;
								idac_q[c].con <= 1'b1;
								idac_q[c].pol <= wi.pol;
								idac_q[c].code <= wi.code;
							end
						end
						O_TRACK: begin
							ttgt_q[c] <= pwdata[7:0];
							if (!lock) begin
								ten_q[c] <= pwdata[T_EN]; // R8
								tpol_q[c] <= pwdata[T_POL];
							end
						end
						O_DELAY: dly_q[c] <= pwdata[DW-1:0]; // R23
						O_SERVO: begin
							svt_q[c] <= pwdata[SW-1:0];
							sv_en_q[c] <= pwdata[S_EN];
							done_q[c] <= 1'b0; // R14
							rch_q[c] <= 1'b0;
							cf_q[c] <= '0;
							lastv_q[c] <= 1'b0;
						end
						default: ;
					endcase
				end
				// tracking start per channel
				if (start_up && ten_q[c] && idac_q[c].con) begin
					act_q[c] <= 1'b1; // R7
					dcnt_q[c] <= dly_q[c];
				end
				if (start_dn && ten_q[c]) begin
					act_q[c] <= 1'b1; // R9
					dcnt_q[c] <= dly_q[c];
					idac_q[c].en <= 1'b1;
					idac_q[c].con <= 1'b0;
					idac_q[c].code <= DAC_MID;
					sc_q[c] <= 1'b1;
					scr_q[c] <= pf.comp[c];
				end
				// delay count then single count ramp
				if (trk_st == TR_RUN && tick && act_q[c] && !sc_q[c]) begin
					if (dcnt_q[c] != '0) begin
						dcnt_q[c] <= dcnt_q[c] - 1'b1; // R5
					end else if (idac_q[c].code < ttgt_q[c]) begin
						idac_q[c].code <= idac_q[c].code + 8'h01;
					end else if (idac_q[c].code > ttgt_q[c]) begin
						idac_q[c].code <= idac_q[c].code - 8'h01; // R10
					end else begin
						act_q[c] <= 1'b0;
						if (!dn_q) begin
							ten_q[c] <= 1'b0; // R6
						end
					end
				end
				if (run_end && dn_q) begin
					ten_q[c] <= 1'b0; // R10
				end
				if (hold_end) begin
					idac_q[c].en <= 1'b0; // R6
					idac_q[c].con <= 1'b0;
				end
				// servo step after each conversion of this channel
				if (cv[c] && sv_act[c] && !lock) begin
					if (!eq[c] && inc[c] && idac_q[c].code != DAC_MAX) begin
						idac_q[c].code <= idac_q[c].code + 8'h01; // R13
					end else if (!eq[c] && !inc[c] &&
							idac_q[c].code != DAC_MIN) begin
						idac_q[c].code <= idac_q[c].code - 8'h01; // R13
					end
					dir_q[c] <= inc[c];
					lastv_q[c] <= 1'b1;
					if (eq[c] || (lastv_q[c] && dir_q[c] != inc[c])) begin
						rch_q[c] <= 1'b1;
					end
					if (rch_q[c] && !done_q[c]) begin
						cf_q[c] <= cf_q[c] + 2'h1;
						if (cf_q[c] == CONF_N - 2'h1) begin
							done_q[c] <= 1'b1; // R14
						end
					end
				end
				if (refire[c]) begin
					done_q[c] <= 1'b0; // R21
					rch_q[c] <= 1'b0;
					cf_q[c] <= '0;
					lastv_q[c] <= 1'b0;
				end
				// limit fault only reported; servo carries on
				if (round_done) begin
					flt_q[c] <= idac_q[c].code == DAC_MIN ||
						idac_q[c].code == DAC_MAX || scf_q[c]; // R25 R18
				end
				// soft connect ramp on the step tick
				if (sc_q[c] && tick) begin
					if (pf.comp[c] != scr_q[c]) begin
						idac_q[c].con <= 1'b1; // R24
						sc_q[c] <= 1'b0;
					end else if (idac_q[c].code == DAC_MIN ||
							idac_q[c].code == DAC_MAX) begin
						sc_q[c] <= 1'b0; // R24
						scf_q[c] <= 1'b1;
						flt_q[c] <= 1'b1;
					end else if (scr_q[c]) begin
						idac_q[c].code <= idac_q[c].code - 8'h01;
					end else begin
						idac_q[c].code <= idac_q[c].code + 8'h01;
					end
				end
				// servo enable cannot survive a disabled dac or tracking
				if (!idac_q[c].en || (wr && wdec[1] && off == O_IDAC &&
						wdec[0] == 1'(c) && !wi.en && !lock)) begin
					sv_en_q[c] <= 1'b0; // R16
				end
				if (lock) begin
					sv_en_q[c] <= 1'b0; // R19
				end
			end
		end
	end

	// read mux, sampled in the setup phase
	always_comb begin
		rd_d = '0;
		if (paddr == A_CTRL) begin
			rd_d[C_SYNC] = (sy_st == SY_WAIT); // R3
			rd_d[C_RUN +: NCH] = run_rel_q;
			rd_d[C_PEND] = pend;
			rd_d[C_CFGLO] = cfg_low_q;
			rd_d[C_BUSY] = (trk_st != TR_IDLE);
		end else if (paddr == A_STAT) begin
			for (int c = 0; c < NCH; c++) begin
				rd_d[c*ST_W +: ST_W] = {scf_q[c], ten_q[c], sc_q[c],
					idac_q[c].con, flt_q[c], done_q[c]};
			end
		end else if (wdec[1]) begin
			case (off)
				O_IDAC: rd_d[IW-1:0] = idac_q[wdec[0]];
				O_TRACK: rd_d[T_POL:0] = {tpol_q[wdec[0]],
					ten_q[wdec[0]], ttgt_q[wdec[0]]};
				O_DELAY: rd_d[DW-1:0] = dly_q[wdec[0]];
				O_SERVO: rd_d[S_EN:0] = {sv_en_q[wdec[0]],
					svt_q[wdec[0]]};
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= rd_d;
		end
	end
endmodule

// ==== tb/tsc_far_model.sv ====
// converter run pins, feedback comparators and adc sequencing model
module tsc_far_model
	import tsc_pkg::*;
(
	input  wire logic                        clk,       // system clock
	input  wire logic                        nrst,      // async reset
	input  wire logic                        cfg_oe,    // config pulled low
	input  wire logic [tsc_pkg::NCH-1:0]     run_oe,    // run pins pulled low
	input  wire logic [tsc_pkg::NCH-1:0][7:0] dac_code, // trim codes
	input  wire logic                        adc_hold,  // no new conversion
	output tsc_pkg::tsc_pins_s               pins,      // pin levels
	output logic                             adc_busy,  // conversion running
	output tsc_pkg::tsc_conv_s               conv,      // conversion end
	output logic                             round_done // both channels done
);
	timeunit 1ns;
	timeprecision 1ns;
	// node level seen by the comparators; arbitrary
	localparam logic [7:0] TRIP = 8'h60;
	logic [2:0] cnt_q;
	logic       ch_q;
	// config and run lines have pull-ups, so a release reads high
	assign pins.cfg = ~cfg_oe;
	assign pins.run = ~run_oe;
	assign pins.comp[0] = dac_code[0] > TRIP;
	assign pins.comp[1] = dac_code[1] > TRIP;
	// eight clocks per conversion, channels in turn; a hold only
	// stops the next start, a running conversion always finishes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 3'h0;
			ch_q <= 1'b0;
			adc_busy <= 1'b0;
			conv <= '0;
			round_done <= 1'b0;
		end else begin
			conv <= '0;
			round_done <= 1'b0;
			if (adc_busy) begin
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h7) begin
					adc_busy <= 1'b0;
					conv.valid <= 1'b1;
					conv.is_a <= 1'b1;
					conv.ch <= ch_q;
					conv.res <= {3'h0, dac_code[ch_q], 4'h0};
					round_done <= ch_q;
					ch_q <= ~ch_q;
				end
			end else if (!adc_hold) begin
				adc_busy <= 1'b1;
			end
		end
	end
endmodule

// ==== tb/tsc_ctrl_assertions.sv ====
// port-level checks for the tracking servo sequencer
module tsc_ctrl_assertions
	import tsc_pkg::*;
#(
	parameter int HOLD_C = tsc_pkg::HOLD_CYC
) (
	input  wire logic                        clk,          // clock
	input  wire logic                        nrst,         // async reset
	input  wire logic                        psel,         // apb select
	input  wire logic                        penable,      // apb access
	input  wire logic                        pwrite,       // apb direction
	input  wire logic [tsc_pkg::AW-1:0]      paddr,        // apb address
	input  wire logic                        pready,       // apb ready
	input  wire logic                        pslverr,      // apb error
	input  tsc_pkg::tsc_pins_s               pins_i,       // pin levels
	input  wire logic                        cfg_oe,       // config low
	input  wire logic [tsc_pkg::NCH-1:0][7:0] dac_code,    // dac codes
	input  wire logic [tsc_pkg::NCH-1:0]     dac_on,       // buffer linked
	input  tsc_pkg::tsc_conv_s               conv_i,       // conversion end
	input  wire logic                        adc_fast,     // 12-bit mode
	input  wire logic                        adc_hold_all  // hold all
);
	timeunit 1ns;
	timeprecision 1ns;
	// release may land a cycle after the hold count runs out
	localparam int H2 = HOLD_C + 2;
	logic vld_q; // conversion end one edge back
	logic wr_q;  // apb write landed one edge back
	logic pend;  // pins show tracking pending
	assign pend = pins_i.cfg && (pins_i.run != 2'b00);
	// history for step checks; a write may move a code by any amount
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vld_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			vld_q <= conv_i.valid;
			wr_q <= psel && penable && pwrite;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	chk_apb_ready: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	chk_unmapped_err: assert property (
		psel && penable && paddr == A_CH_END |-> pslverr)
		else $error("no error on unmapped address");
	// pin sampler lags a few cycles, so pending must stand six edges
	chk_pend_hold: assert property (pend [*6] |-> adc_hold_all)
		else $error("conversions run while tracking pending");
	chk_pend_servo: assert property (pend [*6] |-> !adc_fast)
		else $error("servo active while tracking pending");
	chk_fast_dac: assert property (adc_fast |-> dac_on != 2'b00)
		else $error("servo active with no dac enabled");
	chk_conv_step: assert property (
		adc_fast && $past(dac_on[0]) && !wr_q && $changed(dac_code[0])
		|-> vld_q)
		else $error("servo moved code without a conversion");
	chk_single_step: assert property (
		dac_on[0] && $past(dac_on[0]) && !wr_q |->
		8'(dac_code[0] - $past(dac_code[0])) inside {8'h00, 8'h01, 8'hFF})
		else $error("dac code jumped by more than one count");
	chk_hold_release: assert property (
		$rose(cfg_oe) |-> ##[1:H2] dac_on == 2'b00)
		else $error("dacs not released after hold time");
	chk_down_off: assert property (
		$fell(cfg_oe) |-> dac_on == 2'b00)
		else $error("power-down started with a dac enabled");
	// main flows seen at least once
	cov_power_up: cover property ($rose(cfg_oe));
	cov_power_down: cover property ($fell(cfg_oe));
	cov_servo_reach: cover property (adc_fast ##1 !adc_fast);
endmodule

bind tsc_ctrl tsc_ctrl_assertions #(.HOLD_C(HOLD_C)) u_chk (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.pins_i(pins_i), .cfg_oe(cfg_oe), .dac_code(dac_code),
	.dac_on(dac_on), .conv_i(conv_i), .adc_fast(adc_fast),
	.adc_hold_all(adc_hold_all));

// ==== tb/tb_tsc_ctrl.sv ====
// self-checking bench for the tracking servo sequencer
module tb_tsc_ctrl import tsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk, nrst, psel, penable, pwrite, err;
	logic                pready, pslverr, cfg_o, cfg_oe, adc_busy;
	logic                round_done, adc_fast, adc_hold_oth, adc_hold_all;
	logic [AW-1:0]       paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [NCH-1:0]      run_o, run_oe, dac_on;
	logic [NCH-1:0][7:0] dac_code;
	tsc_pins_s           pins;
	tsc_conv_s           conv;
	int                  fail_count, checked;

	initial clk = 1'b0;
	always #50 clk = ~clk;

	// short counts keep the run brief
	tsc_ctrl #(.STEP_C(2), .HOLD_C(5), .SETTLE_C(5), .SYNC_C(20)) DUT (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins_i(pins), .cfg_o(cfg_o),
		.cfg_oe(cfg_oe), .run_o(run_o), .run_oe(run_oe),
		.dac_code(dac_code), .dac_on(dac_on), .adc_busy(adc_busy),
		.conv_i(conv), .round_done(round_done), .adc_fast(adc_fast),
		.adc_hold_oth(adc_hold_oth), .adc_hold_all(adc_hold_all));

	tsc_far_model far (
		.clk(clk), .nrst(nrst), .cfg_oe(cfg_oe), .run_oe(run_oe),
		.dac_code(dac_code), .adc_hold(adc_hold_all), .pins(pins),
		.adc_busy(adc_busy), .conv(conv), .round_done(round_done));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [AW-1:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// read a flag until it shows the wanted level, bounded
	task automatic poll(input logic [AW-1:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (rd[b] !== v && n < 400);
	endtask

	task automatic results;
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// cuts a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		results;
	end

	initial begin
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0;
		nrst = 1'b0;
		fail_count = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		chk(32'({run_oe, cfg_oe, dac_code[0]}), 32'h600);
		repeat (6) @(posedge clk);
		$display("test reset done");
		apb(1'b1, A_CH_END, 32'hFFFF_FFFF);
		chk(32'(err), 32'h1);
		apb(1'b0, A_CH_END, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("test unmapped done");
		// hard connect channel 0 at a low code, both channels tracked
		apb(1'b1, {4'h1, O_IDAC}, 32'h0000_0710);
		chk(32'({dac_on[0], dac_code[0]}), 32'h110);
		apb(1'b1, {4'h1, O_TRACK}, 32'h0000_0124);
		apb(1'b1, {4'h2, O_TRACK}, 32'h0000_0130);
		apb(1'b1, A_CTRL, 32'h0000_0001);
		apb(1'b0, A_CTRL, 32'h0);
		chk(32'(rd[C_BUSY]), 32'h0);
		$display("test refused go done");
		apb(1'b1, {4'h1, O_SERVO}, 32'h0000_8200);
		chk(32'({adc_fast, adc_hold_oth}), 32'h3);
		poll(A_STAT, 0, 1'b1);
		chk(32'(dac_code[0]), 32'h20);
		repeat (40) @(posedge clk);
		chk(32'(dac_code[0]), 32'h20);
		$display("test servo done");
		apb(1'b1, {4'h1, O_DELAY}, 32'h0000_0002);
		apb(1'b1, A_CTRL, 32'h0000_000C);
		repeat (8) @(posedge clk);
		apb(1'b0, A_CTRL, 32'h0);
		chk(32'(rd[C_PEND]), 32'h1);
		apb(1'b0, {4'h1, O_SERVO}, 32'h0);
		chk(32'(rd[S_EN]), 32'h0);
		apb(1'b1, {4'h1, O_IDAC}, 32'h0000_0740);
		chk(32'(dac_code[0]), 32'h20);
		apb(1'b1, A_CTRL, 32'h0000_000D);
		poll(A_CTRL, C_BUSY, 1'b0);
		chk(32'({cfg_oe, dac_on, dac_code}), 32'h0004_0024);
		apb(1'b0, {4'h1, O_TRACK}, 32'h0);
		chk(32'(rd[T_EN]), 32'h0);
		$display("test power-up done");
		apb(1'b1, {4'h1, O_DELAY}, 32'hFFFF_FFFF);
		apb(1'b0, {4'h1, O_DELAY}, 32'h0);
		chk(rd, 32'h0000_03FF);
		apb(1'b1, {4'h1, O_DELAY}, 32'h0000_0003);
		apb(1'b1, {4'h1, O_TRACK}, 32'h0000_0110);
		apb(1'b1, A_CTRL, 32'h0000_000D);
		poll(A_CTRL, C_BUSY, 1'b0);
		chk(32'({cfg_oe, dac_code}), 32'h0000_3010);
		for (int c = 1; c < 3; c++) begin
			apb(1'b0, {4'(c), O_TRACK}, 32'h0);
			chk(32'(rd[T_EN]), 32'h0);
		end
		apb(1'b1, A_CTRL, 32'h0);
		chk(32'(run_oe), 32'h3);
		$display("test power-down done");
		apb(1'b1, A_CTRL, 32'h0000_0002);
		repeat (10) @(posedge clk);
		apb(1'b0, A_CTRL, 32'h0);
		chk(32'(rd[C_SYNC]), 32'h1);
		repeat (40) @(posedge clk);
		apb(1'b0, A_CTRL, 32'h0);
		chk(32'(rd[C_SYNC]), 32'h0);
		$display("test sync done");
		results;
	end
endmodule
